// ---- hw/touch_pkg.sv ----
// Constants, register map, command codes and state types shared by both link ends.
// Assumes a single 25 MHz pclk and a host-made serial clock of eight pclk periods.
// Contract
// - Mask bits enable X, Y, Z1, Z2, spare
// - Done flag set at end, cleared by read
// - Pen flag set in wake mode, status read clears
// - Reset flag reads one after reset
// - Key 0xDE resets all, others ignored
// - Host writes and reads registers by command
// - Single conversion uses command channel field
// - Sequence code converts enabled channels in order
// - Power-up delay first, settle delay between (each later channel also waits the power-up delay)
// - Host programs sensible power-up and settle delays
// - Spare channel converts inside the sequence
// - Spare pin edges trigger by field
// - Interrupt low during power-up and reset
// - Conversion end asserts interrupt and done flag
// - Reading all data releases interrupt, clears flag (in wake mode the interrupt stays asserted)
// - Wake mode touch asserts interrupt, pen flag
// - Wake mode status read releases interrupt
// - No conversion starts while interrupt asserted
// - Interrupt only pulls low, pull-up releases
// - Invalid channel data reads as 0xFFFF
// - Rate zero manual, nonzero automatic timer
package touch_pkg;
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned CLK_MHZ        = 25;
   localparam int unsigned SCLK_HALF      = 4;
   localparam logic [7:0]  POWERUP_CYCLES = 8'h20;
   // Command byte: [7:5] opcode, [4:0] address or channel field
   localparam logic [2:0] OP_WR_REG  = 3'h0;
   localparam logic [2:0] OP_RD_REG  = 3'h1;
   localparam logic [2:0] OP_RD_DATA = 3'h2;
   localparam logic [2:0] OP_CONVERT = 3'h4;
   localparam logic [2:0] OP_MODE    = 3'h5;
   localparam logic [2:0] SEQUENCE_CODE = 3'h7;
   localparam logic [2:0] NUM_CHAN      = 3'h5;
   // Device register addresses
   localparam logic [4:0] RA_RATE_DELAY  = 5'h00;
   localparam logic [4:0] RA_TRIG_FILTER = 5'h01;
   localparam logic [4:0] RA_SETTLE      = 5'h02;
   localparam logic [4:0] RA_CHAN_MASK   = 5'h04;
   localparam logic [4:0] RA_STATUS      = 5'h05;
   localparam logic [4:0] RA_SOFT_RESET  = 5'h1F;
   localparam logic [7:0] SOFT_RESET_KEY = 8'hDE;
   localparam logic [7:0] CHAN_MASK_RST  = 8'hC0;
   localparam logic [7:0] CHAN_MASK_RW   = 8'hF8;
   localparam logic [7:0] TRIG_FILT_RST  = 8'h20;
   localparam logic [7:0] SETTLE_RW      = 8'h0F;
   localparam int X_BIT = 7, Y_BIT = 6, Z1_BIT = 5, Z2_BIT = 4, SPARE_BIT = 3;
   localparam int DONE_BIT = 7, PEN_BIT = 6, RSTEV_BIT = 5;
   localparam logic [15:0] INVALID_DATA = 16'hFFFF;
   // Host APB register offsets
   localparam logic [11:0] HA_COMMAND = 12'h000;
   localparam logic [11:0] HA_STATUS  = 12'h004;
   localparam logic [11:0] HA_RXDATA  = 12'h008;
   typedef enum logic [1:0] {
      SQ_IDLE = 2'b00,
      SQ_DLY  = 2'b01,
      SQ_CONV = 2'b10
   } seq_t;
   typedef enum logic [1:0] {
      MODE_MANUAL     = 2'b00,
      MODE_TOUCH_TRIG = 2'b01,
      MODE_TOUCH_WAKE = 2'b10
   } mode_t;
   function automatic int unsigned delay_ns(input logic [3:0] code);
      case (code)
         4'h0: delay_ns = 500;
         4'h1: delay_ns = 1100;
         4'h2: delay_ns = 2200;
         4'h3: delay_ns = 4400;
         4'h4: delay_ns = 8900;
         4'h5: delay_ns = 17800;
         4'h6: delay_ns = 35500;
         4'h7: delay_ns = 71000;
         4'h8: delay_ns = 140000;
         4'h9: delay_ns = 280000;
         4'hA: delay_ns = 570000;
         4'hB: delay_ns = 1140000;
         4'hC: delay_ns = 2270000;
         4'hD: delay_ns = 4550000;
         4'hE: delay_ns = 9090000;
         default: delay_ns = 18190000;
      endcase
   endfunction : delay_ns
   function automatic int unsigned delay_cycles(input logic [3:0] code);
      delay_cycles = (delay_ns(code) * CLK_MHZ + 999) / 1000;
   endfunction : delay_cycles
   function automatic int unsigned rate_cps(input logic [3:0] code);
      case (code)
         4'h1: rate_cps = 10;
         4'h2: rate_cps = 20;
         4'h3: rate_cps = 40;
         4'h4: rate_cps = 60;
         4'h5: rate_cps = 80;
         4'h6: rate_cps = 100;
         4'h7: rate_cps = 200;
         4'h8: rate_cps = 300;
         4'h9: rate_cps = 400;
         4'hA: rate_cps = 500;
         4'hB: rate_cps = 1000;
         4'hC: rate_cps = 2000;
         4'hD: rate_cps = 3000;
         4'hE: rate_cps = 4000;
         default: rate_cps = 5000;
      endcase
   endfunction : rate_cps
   function automatic int unsigned rate_cycles(input logic [3:0] code);
      rate_cycles = CLK_HZ / rate_cps(code);
   endfunction : rate_cycles
endpackage : touch_pkg

// ---- hw/touch_link_if.sv ----
// Serial link and open-drain interrupt line between touch device and host.
// Assumes the external pull-up on the interrupt line is modelled here.
`timescale 1ns/10ps
`default_nettype none
interface touch_link_if;
   logic sclk;
   logic ncs_n;
   logic mosi;
   logic miso;
   logic irq_n_drv;
   logic irq_n_oe;
   logic host_interrupt_line_n;
   // Pull-up returns the line high when nobody drives it
   assign host_interrupt_line_n = irq_n_oe ? irq_n_drv : 1'b1;
   modport dev (
      input  sclk,
      input  ncs_n,
      input  mosi,
      output miso,
      output irq_n_drv,
      output irq_n_oe
   );
   modport host (
      output sclk,
      output ncs_n,
      output mosi,
      input  miso,
      input  host_interrupt_line_n
   );
endinterface : touch_link_if
`default_nettype wire

// ---- hw/touch_dev.sv ----
// Touch device end: serial slave, registers, conversion sequencer, interrupt.
// Assumes a 12-bit converter on the user side answering adc_start with adc_done.
`timescale 1ns/10ps
`default_nettype none
module touch_dev #(
   parameter int unsigned CNT_SHIFT = 0
) (
   touch_link_if.dev        link,
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pen_down,
   input  wire logic        aux_pin,
   input  wire logic        adc_done,
   input  wire logic [11:0] adc_result,
   output logic             adc_start,
   output logic [2:0]       adc_chan
);
   typedef struct packed {
      logic [1:0]          sclk_s;
      logic [1:0]          ncs_s;
      logic [1:0]          mosi_s;
      logic [1:0]          pen_s;
      logic [1:0]          aux_s;
      logic                sclk_d;
      logic                pen_d;
      logic                aux_d;
      logic                hdr;
      logic [3:0]          bc;
      logic [7:0]          sh;
      logic [7:0]          cmd;
      logic [15:0]         tx;
      logic                miso;
      logic [7:0]          ctrl0;
      logic [7:0]          ctrl1;
      logic [7:0]          ctrl2;
      logic [7:0]          mask;
      logic                conv_f;
      logic                pen_f;
      logic                rst_f;
      logic                irq;
      logic                pwr;
      logic [7:0]          pwr_cnt;
      touch_pkg::mode_t    mode;
      touch_pkg::seq_t     sq;
      logic [4:0]          pend;
      logic [2:0]          cur;
      logic [2:0]          samp;
      logic [31:0]         dly;
      logic [31:0]         rate;
      logic [4:0]          valid;
      logic [4:0]          unread;
      logic [59:0]         data;
      logic                adc_start;
      logic [2:0]          adc_chan;
   } dev_state_t;

   function automatic dev_state_t rst_state();
      dev_state_t r;
      r         = '0;
      r.sclk_s  = 2'h0;
      r.ncs_s   = 2'h3;
      r.ctrl1   = touch_pkg::TRIG_FILT_RST;
      r.mask    = touch_pkg::CHAN_MASK_RST;
      r.rst_f   = 1'b1;
      r.irq     = 1'b1;
      r.pwr_cnt = touch_pkg::POWERUP_CYCLES;
      r.mode    = touch_pkg::MODE_MANUAL;
      r.sq      = touch_pkg::SQ_IDLE;
      rst_state = r;
   endfunction : rst_state

   localparam dev_state_t RST_S = rst_state();

   function automatic logic [2:0] first_idx(input logic [4:0] m);
      first_idx = 3'h0;
      for (int i = 4; i >= 0; i--) begin
         if (m[i]) begin
            first_idx = 3'(i);
         end
      end
   endfunction : first_idx

   function automatic logic [31:0] scaled(input int unsigned v);
      int unsigned t;
      t = v >> CNT_SHIFT;
      scaled = (t == 0) ? 32'h1 : t[31:0];
   endfunction : scaled

   dev_state_t s_r;
   dev_state_t s_nxt;

   always_comb begin
      logic       sclk, ncs, mosi, pen, aux, rise, fall, pen_rise;
      logic       wr, ld_reg, ld_word, srst, trig, cmd_trig;
      logic [4:0] addr, all5, tmask, rest;
      logic [7:0] wd;
      logic [2:0] i;
      s_nxt     = s_r;
      sclk = s_r.sclk_s[1];
      ncs = s_r.ncs_s[1];
      mosi = s_r.mosi_s[1];
      pen = s_r.pen_s[1];
      aux = s_r.aux_s[1];
      rise = sclk & ~s_r.sclk_d;
      fall = ~sclk & s_r.sclk_d;
      pen_rise = pen & ~s_r.pen_d;
      wr = 1'b0;
      ld_reg = 1'b0;
      ld_word = 1'b0;
      srst = 1'b0;
      trig = 1'b0;
      cmd_trig = 1'b0;
      addr = s_r.cmd[4:0];
      wd = 8'h00;
      tmask = 5'h00;
      rest = 5'h00;
      i = 3'h0;
      all5 = {s_r.mask[touch_pkg::SPARE_BIT], s_r.mask[touch_pkg::Z2_BIT],
              s_r.mask[touch_pkg::Z1_BIT], s_r.mask[touch_pkg::Y_BIT],
              s_r.mask[touch_pkg::X_BIT]};
      s_nxt.adc_start = 1'b0;
      s_nxt.sclk_s = {s_r.sclk_s[0], link.sclk};
      s_nxt.ncs_s  = {s_r.ncs_s[0], link.ncs_n};
      s_nxt.mosi_s = {s_r.mosi_s[0], link.mosi};
      s_nxt.pen_s  = {s_r.pen_s[0], pen_down};
      s_nxt.aux_s  = {s_r.aux_s[0], aux_pin};
      s_nxt.sclk_d = sclk;
      s_nxt.pen_d  = pen;
      s_nxt.aux_d  = aux;
      if (!s_r.pwr) begin
         if (s_r.pwr_cnt == 8'h00) begin
            s_nxt.pwr = 1'b1;
            s_nxt.irq = 1'b0;
         end else begin
            s_nxt.pwr_cnt = s_r.pwr_cnt - 8'h01;
         end
      end
      // Serial slave: sample on rising sclk, shift out on falling
      if (ncs) begin
         s_nxt.hdr = 1'b0;
         s_nxt.bc  = 4'h0;
      end else if (rise) begin
         s_nxt.sh = {s_r.sh[6:0], mosi};
         s_nxt.bc = s_r.bc + 4'h1;
         if (!s_r.hdr) begin
            if (s_r.bc == 4'h7) begin
               s_nxt.hdr = 1'b1;
               s_nxt.bc  = 4'h0;
               s_nxt.cmd = {s_r.sh[6:0], mosi};
               addr = s_nxt.cmd[4:0];
               case (s_nxt.cmd[7:5])
                  touch_pkg::OP_RD_REG:  ld_reg = 1'b1;
                  touch_pkg::OP_RD_DATA: ld_word = 1'b1;
                  touch_pkg::OP_CONVERT: cmd_trig = 1'b1;
                  touch_pkg::OP_MODE: begin
                     if (s_nxt.cmd[1:0] != 2'b11) begin
                        s_nxt.mode = touch_pkg::mode_t'(s_nxt.cmd[1:0]);
                     end
                  end
                  default: ;
               endcase
            end
         end else begin
            case (s_r.cmd[7:5])
               touch_pkg::OP_WR_REG: begin
                  wr = (s_r.bc == 4'h7);
                  wd = {s_r.sh[6:0], mosi};
               end
               touch_pkg::OP_RD_DATA: ld_word = (s_r.bc == 4'hF);
               default: ;
            endcase
         end
      end
      if (fall && !ncs) begin
         s_nxt.miso = s_r.tx[15];
         s_nxt.tx   = {s_r.tx[14:0], 1'b0};
      end
      if (wr) begin
         case (addr)
            touch_pkg::RA_RATE_DELAY:  s_nxt.ctrl0 = wd;
            touch_pkg::RA_TRIG_FILTER: s_nxt.ctrl1 = wd;
            touch_pkg::RA_SETTLE:      s_nxt.ctrl2 = wd & touch_pkg::SETTLE_RW;
            touch_pkg::RA_CHAN_MASK:   s_nxt.mask = wd & touch_pkg::CHAN_MASK_RW;
            touch_pkg::RA_SOFT_RESET:  srst = (wd == touch_pkg::SOFT_RESET_KEY);
            default: ;
         endcase
      end
      if (ld_reg) begin
         case (addr)
            touch_pkg::RA_RATE_DELAY:  s_nxt.tx = {s_r.ctrl0, 8'h00};
            touch_pkg::RA_TRIG_FILTER: s_nxt.tx = {s_r.ctrl1, 8'h00};
            touch_pkg::RA_SETTLE:      s_nxt.tx = {s_r.ctrl2, 8'h00};
            touch_pkg::RA_CHAN_MASK:   s_nxt.tx = {s_r.mask, 8'h00};
            touch_pkg::RA_STATUS: begin
               s_nxt.tx = {s_r.conv_f, s_r.pen_f, s_r.rst_f, 5'h00, 8'h00};
               s_nxt.pen_f = 1'b0;
               s_nxt.rst_f = 1'b0;
               if (s_r.mode == touch_pkg::MODE_TOUCH_WAKE) begin
                  s_nxt.irq = 1'b0;
               end
            end
            default: s_nxt.tx = 16'h0000;
         endcase
      end
      if (ld_word) begin
         s_nxt.tx = touch_pkg::INVALID_DATA;
         if (|s_r.unread) begin
            i = first_idx(s_r.unread);
            if (s_r.valid[i]) begin
               s_nxt.tx = {1'b0, i, s_r.data[i*12 +: 12]};
            end
            s_nxt.unread[i] = 1'b0;
            if (s_nxt.unread == 5'h00) begin
               s_nxt.conv_f = 1'b0;
               if (s_r.mode != touch_pkg::MODE_TOUCH_WAKE) begin
                  s_nxt.irq = 1'b0;
               end
            end
         end
      end
      if (s_r.mode == touch_pkg::MODE_TOUCH_WAKE && pen_rise) begin
         s_nxt.pen_f = 1'b1;
         s_nxt.irq   = 1'b1;
      end
      // Start sources
      if (cmd_trig) begin
         if (s_nxt.cmd[2:0] == touch_pkg::SEQUENCE_CODE) begin
            tmask = all5;
         end else if (s_nxt.cmd[2:0] < touch_pkg::NUM_CHAN) begin
            tmask = 5'h01 << s_nxt.cmd[2:0];
         end
         trig = 1'b1;
      end
      if (s_r.mode == touch_pkg::MODE_MANUAL && s_r.ctrl0[7:4] != 4'h0) begin
         if (s_r.rate <= 32'h1) begin
            s_nxt.rate = scaled(touch_pkg::rate_cycles(s_r.ctrl0[7:4]));
            trig = 1'b1;
            tmask = all5;
         end else begin
            s_nxt.rate = s_r.rate - 32'h1;
         end
      end else begin
         s_nxt.rate = 32'h0;
      end
      if (s_r.mode == touch_pkg::MODE_MANUAL && s_r.ctrl0[7:4] == 4'h0 &&
          ((s_r.ctrl1[6] && aux && !s_r.aux_d) ||
           (s_r.ctrl1[7] && !aux && s_r.aux_d))) begin
         trig = 1'b1;
         tmask = all5;
      end
      if (s_r.mode == touch_pkg::MODE_TOUCH_TRIG && pen_rise) begin
         trig = 1'b1;
         tmask = all5;
      end
      if (trig && tmask != 5'h00 && s_r.sq == touch_pkg::SQ_IDLE &&
          !s_r.irq && s_r.pwr) begin
         s_nxt.pend   = tmask;
         s_nxt.valid  = 5'h00;
         s_nxt.unread = 5'h00;
         s_nxt.cur    = first_idx(tmask);
         s_nxt.samp   = {s_r.ctrl1[1:0], 1'b0};
         s_nxt.dly    = scaled(touch_pkg::delay_cycles(s_r.ctrl0[3:0]));
         s_nxt.sq     = touch_pkg::SQ_DLY;
      end
      case (s_r.sq)
         touch_pkg::SQ_IDLE: ;
         touch_pkg::SQ_DLY: begin
            if (s_r.dly <= 32'h1) begin
               s_nxt.adc_start = 1'b1;
               s_nxt.adc_chan  = s_r.cur;
               s_nxt.sq        = touch_pkg::SQ_CONV;
            end else begin
               s_nxt.dly = s_r.dly - 32'h1;
            end
         end
         touch_pkg::SQ_CONV: begin
            if (adc_done) begin
               s_nxt.data[s_r.cur*12 +: 12] = adc_result;
               s_nxt.valid[s_r.cur]  = pen;
               s_nxt.unread[s_r.cur] = 1'b1;
               rest = s_r.pend;
               rest[s_r.cur] = 1'b0;
               if (s_r.samp != 3'h0) begin
                  s_nxt.samp = s_r.samp - 3'h1;
                  s_nxt.dly  = scaled(touch_pkg::delay_cycles(s_r.ctrl2[3:0]));
                  s_nxt.sq   = touch_pkg::SQ_DLY;
               end else if (rest != 5'h00) begin
                  s_nxt.pend = rest;
                  s_nxt.cur  = first_idx(rest);
                  s_nxt.samp = {s_r.ctrl1[1:0], 1'b0};
                  s_nxt.dly  = scaled(touch_pkg::delay_cycles(s_r.ctrl0[3:0]));
                  s_nxt.sq   = touch_pkg::SQ_DLY;
               end else begin
                  s_nxt.pend   = 5'h00;
                  s_nxt.sq     = touch_pkg::SQ_IDLE;
                  s_nxt.conv_f = 1'b1;
                  s_nxt.irq    = 1'b1;
               end
            end
         end
         default: s_nxt.sq = touch_pkg::SQ_IDLE;
      endcase
      if (srst) begin
         s_nxt = RST_S;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= RST_S;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.miso      = s_r.miso;
   assign link.irq_n_drv = 1'b0;
   assign link.irq_n_oe  = s_r.irq;
   assign adc_start      = s_r.adc_start;
   assign adc_chan       = s_r.adc_chan;
endmodule : touch_dev
`default_nettype wire

// ---- hw/touch_host.sv ----
// Host end: APB slave with command, status and receive registers; serial master.
// Assumes software waits for busy to clear before writing the next command.
`timescale 1ns/10ps
`default_nettype none
module touch_host (
   touch_link_if.host       link,
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   typedef struct packed {
      logic [1:0]  miso_s;
      logic [1:0]  irq_s;
      logic        busy;
      logic        ncs;
      logic        sclk;
      logic        mosi;
      logic [2:0]  div;
      logic [7:0]  bits;
      logic [15:0] tx;
      logic [31:0] rx;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } host_state_t;

   localparam logic [2:0] HALF_M1 = 3'(touch_pkg::SCLK_HALF - 1);

   host_state_t s_r;
   host_state_t s_nxt;

   always_comb begin
      logic acc;
      s_nxt = s_r;
      acc = psel & penable & s_r.pready;
      s_nxt.miso_s = {s_r.miso_s[0], link.miso};
      s_nxt.irq_s  = {s_r.irq_s[0], link.host_interrupt_line_n};
      s_nxt.pready = psel & penable & ~s_r.pready;
      s_nxt.pslverr = 1'b0;
      if (psel && penable && !s_r.pready) begin
         case (paddr)
            touch_pkg::HA_COMMAND: s_nxt.prdata = 32'h0;
            touch_pkg::HA_STATUS:  s_nxt.prdata = {30'h0, ~s_r.irq_s[1], s_r.busy};
            touch_pkg::HA_RXDATA:  s_nxt.prdata = s_r.rx;
            default: begin
               s_nxt.prdata  = 32'h0;
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end
      if (acc && pwrite && paddr == touch_pkg::HA_COMMAND && !s_r.busy) begin
         s_nxt.busy = 1'b1;
         s_nxt.ncs  = 1'b0;
         s_nxt.sclk = 1'b0;
         s_nxt.tx   = {pwdata[6:0], pwdata[15:8], 1'b0};
         s_nxt.mosi = pwdata[7];
         s_nxt.div  = HALF_M1;
         s_nxt.bits = {pwdata[19:16], 3'h0} + 8'h08;
      end else if (s_r.busy) begin
         if (s_r.div != 3'h0) begin
            s_nxt.div = s_r.div - 3'h1;
         end else begin
            s_nxt.div = HALF_M1;
            if (s_r.bits == 8'h00) begin
               s_nxt.busy = 1'b0;
            end else if (!s_r.sclk) begin
               s_nxt.sclk = 1'b1;
            end else begin
               // Sample late in the high phase to cover sync latency
               s_nxt.rx   = {s_r.rx[30:0], s_r.miso_s[1]};
               s_nxt.sclk = 1'b0;
               s_nxt.bits = s_r.bits - 8'h01;
               s_nxt.mosi = s_r.tx[15];
               s_nxt.tx   = {s_r.tx[14:0], 1'b0};
               if (s_r.bits == 8'h01) begin
                  s_nxt.ncs = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{miso_s: 2'h0, irq_s: 2'h3, ncs: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.sclk  = s_r.sclk;
   assign link.ncs_n = s_r.ncs;
   assign link.mosi  = s_r.mosi;
   assign prdata     = s_r.prdata;
   assign pready     = s_r.pready;
   assign pslverr    = s_r.pslverr;
endmodule : touch_host
`default_nettype wire

// ---- tb/touch_link_sva.sv ----
// Checker for the serial link and interrupt line joining device and host ends.
// Assumes it watches the one interface instance that both design ends share.
`timescale 1ns/10ps
`default_nettype none
module touch_link_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sclk,
   input wire logic ncs_n,
   input wire logic mosi,
   input wire logic irq_n_drv,
   input wire logic irq_n_oe,
   input wire logic host_interrupt_line_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_drive_only_low: assert property (irq_n_oe |-> !irq_n_drv)
      else $error("interrupt line driven high");
   a_line_pulled_high: assert property (!irq_n_oe |-> host_interrupt_line_n)
      else $error("released line not high");
   a_line_low_driven: assert property (!host_interrupt_line_n |-> irq_n_oe)
      else $error("line low without device drive");
   a_reset_holds_low: assert property ($rose(presetn) |-> irq_n_oe [*8])
      else $error("line not low after reset");
   a_powerup_release: assert property ($rose(presetn) |-> ##[30:40] !irq_n_oe)
      else $error("line not released after power-up");
   a_sclk_idle_low: assert property (ncs_n |-> !sclk)
      else $error("serial clock runs outside frame");
   a_sclk_half_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("serial clock high phase not four cycles");
   a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("host data moved while clock high");
endmodule : touch_link_sva
`default_nettype wire

// ---- tb/touch_channel_seq_irq_tb_top.sv ----
// Testbench joining device and host ends; software side driven over APB.
// Assumes a simple converter model answering each start one cycle later.
`timescale 1ns/10ps
`default_nettype none
module touch_channel_seq_irq_tb_top;
   logic        pclk       = 1'b0;
   logic        presetn    = 1'b0;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [11:0] paddr      = 12'h000;
   logic [31:0] pwdata     = 32'h0000_0000;
   logic        pen_down   = 1'b1;
   logic        aux_pin    = 1'b0;
   logic        adc_done   = 1'b0;
   logic [11:0] adc_result = 12'h000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, slv, adc_start;
   logic [2:0]  adc_chan;
   logic [2:0]  seen [0:15];
   int          err_count = 0, samples_checked = 0, nconv = 0, base;
   touch_link_if link ();
   touch_dev i_touch_dev (.link(link), .pclk(pclk), .presetn(presetn), .pen_down(pen_down),
      .aux_pin(aux_pin), .adc_done(adc_done), .adc_result(adc_result),
      .adc_start(adc_start), .adc_chan(adc_chan));
   touch_host i_touch_host (.link(link), .pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   touch_link_sva i_touch_link_sva (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
      .ncs_n(link.ncs_n), .mosi(link.mosi), .irq_n_drv(link.irq_n_drv),
      .irq_n_oe(link.irq_n_oe), .host_interrupt_line_n(link.host_interrupt_line_n));
   always #20 pclk = ~pclk;
   // Converter model: result carries the channel so order shows in the data
   always @(posedge pclk) begin
      adc_done <= adc_start;
      adc_result <= {9'h140, adc_chan};
      if (adc_start === 1'b1) begin
         seen[nconv[3:0]] <= adc_chan;
         nconv <= nconv + 1;
      end
   end
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t exp %h got %h", $time, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Sends one command frame and waits for the host end to go idle
   task automatic cmd(input logic [7:0] c, input logic [7:0] d, input logic [3:0] n);
      apb(1'b1, touch_pkg::HA_COMMAND, {12'h000, n, d, c});
      do begin
         apb(1'b0, touch_pkg::HA_STATUS, 32'h0000_0000);
      end while (rd[0] !== 1'b0);
      apb(1'b0, touch_pkg::HA_RXDATA, 32'h0000_0000);
   endtask : cmd
   task automatic rreg(input logic [4:0] a, input logic [7:0] exp);
      cmd({touch_pkg::OP_RD_REG, a}, 8'h00, 4'h1);
      chk({24'h000000, exp}, {24'h000000, rd[7:0]});
   endtask : rreg
   task automatic wreg(input logic [4:0] a, input logic [7:0] d);
      cmd({touch_pkg::OP_WR_REG, a}, d, 4'h1);
   endtask : wreg
   // One touch: pen lifted for a few cycles, then down again
   task automatic tap;
      pen_down <= 1'b0;
      repeat (4) @(posedge pclk);
      pen_down <= 1'b1;
   endtask : tap
   task automatic wait_line(input logic lvl);
      int k;
      k = 0;
      do begin
         apb(1'b0, touch_pkg::HA_STATUS, 32'h0000_0000);
         k++;
      end while (rd[1] !== lvl && k < 500);
      chk({31'h0, lvl}, {31'h0, rd[1]});
   endtask : wait_line
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   initial begin
      #2_000_000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, touch_pkg::HA_STATUS, 32'h0000_0000);
      chk(32'h2, rd & 32'h2);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(32'h1, {31'h0, slv});
      wait_line(1'b0);
      rreg(touch_pkg::RA_CHAN_MASK, 8'hC0);
      rreg(touch_pkg::RA_STATUS, 8'h20);
      $display("reset test done");
      wreg(touch_pkg::RA_CHAN_MASK, 8'hFF);
      rreg(touch_pkg::RA_CHAN_MASK, 8'hF8);
      wreg(touch_pkg::RA_STATUS, 8'hFF);
      rreg(touch_pkg::RA_STATUS, 8'h00);
      $display("register test done");
      base = nconv;
      cmd({touch_pkg::OP_CONVERT, 2'b00, touch_pkg::SEQUENCE_CODE}, 8'h00, 4'h0);
      wait_line(1'b1);
      for (int i = 0; i < 5; i++)
         chk(i, {29'h0, seen[base + i]});
      rreg(touch_pkg::RA_STATUS, 8'h80);
      cmd({touch_pkg::OP_RD_DATA, 5'h00}, 8'h00, 4'hA);
      chk(32'h3A03_4A04, rd);
      wait_line(1'b0);
      rreg(touch_pkg::RA_STATUS, 8'h00);
      $display("sequence test done");
      base = nconv;
      cmd({touch_pkg::OP_CONVERT, 5'h01}, 8'h00, 4'h0);
      wait_line(1'b1);
      cmd({touch_pkg::OP_CONVERT, 5'h02}, 8'h00, 4'h0);
      repeat (60) @(posedge pclk);
      chk(32'h1, nconv - base);
      cmd({touch_pkg::OP_RD_DATA, 5'h00}, 8'h00, 4'h4);
      chk(32'h1A01_FFFF, rd);
      $display("single test done");
      cmd({touch_pkg::OP_MODE, 5'h02}, 8'h00, 4'h0);
      tap();
      wait_line(1'b1);
      rreg(touch_pkg::RA_STATUS, 8'h40);
      wait_line(1'b0);
      cmd({touch_pkg::OP_MODE, 5'h01}, 8'h00, 4'h0);
      base = nconv;
      tap();
      wait_line(1'b1);
      chk(32'h5, nconv - base);
      cmd({touch_pkg::OP_RD_DATA, 5'h00}, 8'h00, 4'hA);
      wait_line(1'b0);
      cmd({touch_pkg::OP_MODE, 5'h00}, 8'h00, 4'h0);
      $display("touch mode test done");
      wreg(touch_pkg::RA_TRIG_FILTER, 8'h21);
      wreg(touch_pkg::RA_RATE_DELAY, 8'h01);
      base = nconv;
      cmd({touch_pkg::OP_CONVERT, 5'h00}, 8'h00, 4'h0);
      wait_line(1'b1);
      chk(32'h3, nconv - base);
      cmd({touch_pkg::OP_RD_DATA, 5'h00}, 8'h00, 4'h2);
      chk(32'h0A00, rd & 32'hFFFF);
      $display("filter test done");
      wreg(touch_pkg::RA_TRIG_FILTER, 8'h60);
      base = nconv;
      aux_pin <= 1'b1;
      wait_line(1'b1);
      chk(32'h1, {31'h0, nconv > base});
      $display("trigger test done");
      wreg(touch_pkg::RA_SOFT_RESET, 8'hAB);
      rreg(touch_pkg::RA_TRIG_FILTER, 8'h60);
      wreg(touch_pkg::RA_SOFT_RESET, touch_pkg::SOFT_RESET_KEY);
      wait_line(1'b0);
      rreg(touch_pkg::RA_CHAN_MASK, 8'hC0);
      rreg(touch_pkg::RA_TRIG_FILTER, 8'h20);
      $display("soft reset test done");
      end_sim();
   end
endmodule : touch_channel_seq_irq_tb_top
`default_nettype wire
